// ===== rtl/limit_channel.sv
/*
  One limit channel: threshold select, hysteresis compare, activation
  pattern, switch-on/off delay and telegram scheduling.
  Assumes a one-cycle second tick and samples on the same clock.
*/
`timescale 1ns/1ps
module limit_channel
(
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic enable, // Channel active
  input wire logic sec_tick, // One-second pulse
  input wire logic sample_valid, // New wind speed sample
  input wire logic [15:0] speed, // Wind speed, m/s
  input wire logic [3:0] level_sel, // Fixed threshold index
  input wire logic [2:0] hyst_sel, // Hysteresis index
  input wire logic [3:0] pattern, // Activation pattern
  input wire logic [1:0] ext_mode, // External threshold source
  input wire logic ext16_valid, // 2-byte threshold received
  input wire logic [15:0] ext16, // 2-byte threshold
  input wire logic ext8_valid, // 1-byte threshold received
  input wire logic [7:0] ext8, // 1-byte threshold
  input wire logic teach, // Teach switching object
  input wire logic download, // Configuration download
  input wire logic [3:0] on_dly_sel, // Switch-on delay index
  input wire logic [3:0] off_dly_sel, // Switch-off delay index
  input wire logic send_on_change, // Send on value change
  input wire logic [6:0] cyclic, // Cyclic period x 10 s
  output logic limit_value, // Limit object value
  output logic send, // Telegram request pulse
  output logic [15:0] threshold_level // Threshold in use
);

  // ***************************************************************
  // Threshold and comparison
  // ***************************************************************
  logic [15:0] ext_level;
  logic ext_loaded;
  logic target;
  logic pending;
  logic [13:0] dly_cnt;
  logic [10:0] cyc_cnt;
  logic sampled;

  // Pattern fields: bit3 undershoot-driven, bit2 polarity of trigger,
  // bits1:0 0 both send, 1 return silent, 2 trigger silent
  wire under_drv = pattern[3];
  wire trig_pol = ~pattern[2];
  wire trig_silent = (pattern[1:0] == 2'h2);
  wire ret_silent = (pattern[1:0] == 2'h1);
  wire [15:0] fixed_level = {8'h00, wind_limit_pkg::speed_of(level_sel)};
  wire [15:0] hyst = {8'h00, wind_limit_pkg::hyst_of(hyst_sel)};
  wire use_ext = (ext_mode != wind_limit_pkg::EXT_NONE) && ext_loaded;
  wire [15:0] level = use_ext ? ext_level : fixed_level;
  wire [16:0] up_thr = {1'b0, level} + {1'b0, hyst};
  wire [15:0] dn_thr = (level > hyst) ? level - hyst : 16'h0000;
  wire above = under_drv ? ({1'b0, speed} > up_thr) : (speed > level);
  wire below = under_drv ? (speed < level) : (speed < dn_thr);
  // Trigger condition is the "exceed" side, or "undershoot" when reversed
  wire trig_cond = under_drv ? below : above;
  wire ret_cond = under_drv ? above : below;
  wire trig_state = trig_pol;
  wire silent_now = (target == trig_state) ? trig_silent : ret_silent;
  wire [13:0] dly_len = target ? wind_limit_pkg::delay_of(on_dly_sel)
                               : wind_limit_pkg::delay_of(off_dly_sel);
  wire [10:0] cyc_len = 11'(cyclic) * 11'(wind_limit_pkg::CYCLIC_UNIT_S);
  wire accept = pending && (dly_cnt >= dly_len);
  wire change_send = accept && (target != limit_value) && send_on_change
                     && !silent_now;
  wire cyc_send = (cyclic != 7'h00) && sec_tick && (cyc_cnt + 11'h001 >=
                   cyc_len) && !silent_now;

  // External threshold; a value arriving with a download is kept,
  // so a fresh object is never lost to the clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ext_level <= 16'h0000;
      ext_loaded <= 1'b0;
    end
    else if (ce)
    begin
      if (teach)
      begin
        ext_level <= speed;
        ext_loaded <= 1'b1;
      end
      else if (ext_mode == wind_limit_pkg::EXT_16BIT && ext16_valid)
      begin
        ext_level <= ext16;
        ext_loaded <= 1'b1;
      end
      else if (ext_mode == wind_limit_pkg::EXT_8BIT && ext8_valid)
      begin
        ext_level <= {8'h00, ext8};
        ext_loaded <= 1'b1;
      end
      else if (download)
        ext_loaded <= 1'b0;
    end
  end

  // ***************************************************************
  // Target, delay and output object
  // ***************************************************************
  // Target moves only on a sample; a reversal restarts the delay
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      target <= wind_limit_pkg::LIMIT_RESET;
      pending <= 1'b0;
      dly_cnt <= 14'h0000;
      limit_value <= wind_limit_pkg::LIMIT_RESET;
      sampled <= 1'b0;
    end
    else if (ce)
    begin
      if (!enable)
      begin
        pending <= 1'b0;
        dly_cnt <= 14'h0000;
      end
      else if (sample_valid && trig_cond && target != trig_state)
      begin
        target <= trig_state;
        pending <= (trig_state != limit_value);
        dly_cnt <= 14'h0000;
      end
      else if (sample_valid && ret_cond && target == trig_state)
      begin
        target <= ~trig_state;
        pending <= (~trig_state != limit_value);
        dly_cnt <= 14'h0000;
      end
      else if (accept)
      begin
        limit_value <= target;
        pending <= 1'b0;
      end
      else if (pending && sec_tick)
        dly_cnt <= dly_cnt + 14'h0001;
      if (sample_valid)
        sampled <= 1'b1;
    end
  end

  // Cyclic period counter in seconds
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cyc_cnt <= 11'h000;
    else if (ce)
    begin
      if (!enable || cyclic == 7'h00 || cyc_send)
        cyc_cnt <= 11'h000;
      else if (sec_tick)
        cyc_cnt <= (cyc_cnt + 11'h001 >= cyc_len) ? 11'h000
                                                  : cyc_cnt + 11'h001;
    end
  end

  // Telegram requests; silent conditions also mute cyclic sends
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      send <= 1'b0;
    else if (ce)
      send <= enable && sampled && (change_send || cyc_send);
  end

  assign threshold_level = level;

endmodule

// ===== rtl/wind_limit_pkg.sv
/*
  Shared constants for the two-channel wind speed limit monitor: threshold
  and hysteresis tables, external threshold source codes, delay table, timing.
  Assumes a 10 MHz system clock.
*/
package wind_limit_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned SECOND_NS = 1_000_000_000;
  localparam int unsigned CLOCK_PERIOD_NS = SECOND_NS / CLOCK_HZ;
  localparam int unsigned SECOND_CYCLES = SECOND_NS / CLOCK_PERIOD_NS;
  localparam int unsigned CYCLIC_UNIT_S = 10;
  localparam int unsigned CYCLIC_MAX = 120;

  // ***************************************************************
  // Configuration widths and reset values
  // ***************************************************************
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned PAT_W = 4;
  localparam int unsigned EXT_W = 2;
  localparam int unsigned CYC_W = 7;
  localparam int unsigned DLY_W = 14;
  localparam logic LIMIT_RESET = 1'b0;

  // External threshold sources
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_16BIT = 2'h1;
  localparam logic [1:0] EXT_8BIT = 2'h2;

  // Fixed threshold table, index 0..11, in m/s
  function automatic logic [7:0] speed_of(input logic [3:0] sel);
    case (sel)
      4'h0: speed_of = 8'h01;
      4'h1: speed_of = 8'h03;
      4'h2: speed_of = 8'h05;
      4'h3: speed_of = 8'h08;
      4'h4: speed_of = 8'h0A;
      4'h5: speed_of = 8'h0C;
      4'h6: speed_of = 8'h0F;
      4'h7: speed_of = 8'h14;
      4'h8: speed_of = 8'h16;
      4'h9: speed_of = 8'h19;
      4'hA: speed_of = 8'h1E;
      default: speed_of = 8'h23;
    endcase
  endfunction

  // Hysteresis table: none, 1, 3, 5, 8, 10 m/s
  function automatic logic [7:0] hyst_of(input logic [2:0] sel);
    case (sel)
      3'h1: hyst_of = 8'h01;
      3'h2: hyst_of = 8'h03;
      3'h3: hyst_of = 8'h05;
      3'h4: hyst_of = 8'h08;
      3'h5: hyst_of = 8'h0A;
      default: hyst_of = 8'h00;
    endcase
  endfunction

  // Delay table in seconds: none,1,3,5,10,15,30,60,180,300,600,900,1800,3600
  function automatic logic [13:0] delay_of(input logic [3:0] sel);
    case (sel)
      4'h1: delay_of = 14'h0001;
      4'h2: delay_of = 14'h0003;
      4'h3: delay_of = 14'h0005;
      4'h4: delay_of = 14'h000A;
      4'h5: delay_of = 14'h000F;
      4'h6: delay_of = 14'h001E;
      4'h7: delay_of = 14'h003C;
      4'h8: delay_of = 14'h00B4;
      4'h9: delay_of = 14'h012C;
      4'hA: delay_of = 14'h0258;
      4'hB: delay_of = 14'h0384;
      4'hC: delay_of = 14'h0708;
      4'hD: delay_of = 14'h0E10;
      default: delay_of = 14'h0000;
    endcase
  endfunction

endpackage

// ===== rtl/wind_speed_limit_monitor.sv
/*
  Two-channel wind speed limit monitor with a one-second prescaler and a
  three-stage synchroniser on the teach inputs.
  Assumes samples and bus objects arrive as one-cycle strobes in the
  clock domain; teach buttons may be asynchronous.
*/
// Behaviour
// - Two channels; second only when enabled
// - Twelve fixed thresholds from 1 to 35
// - Hysteresis none,1,3,5,8,10 offsets return
// - Exceed sets one polarity, undershoot minus returns
// - Undershoot sets one polarity, exceed plus returns
// - One direction may send no telegram
// - Silent condition also suppresses cyclic sends
// - External 2-byte threshold used when selected
// - External 1-byte threshold used when selected
// - Teach captures current speed as threshold when an external source is selected
// - Download restores configured; new value needed
// - Switch-on delay holds output at zero
// - Switch-off delay holds output at one
// - Send on every change when enabled
// - No change sends when disabled
// - Cyclic period ten times setting; zero off
// - Cyclic sends regardless of change
// - Both off means never send
`timescale 1ns/1ps
module wind_speed_limit_monitor
(
  input wire logic clock, // System clock, 10 MHz
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic both_limits, // Second channel enabled
  input wire logic sample_valid, // New wind speed sample
  input wire logic [15:0] speed, // Wind speed, m/s
  input wire logic download, // Configuration download
  input wire logic [7:0] level_sel, // Threshold index, ch1 low nibble
  input wire logic [5:0] hyst_sel, // Hysteresis index, ch1 low
  input wire logic [7:0] pattern, // Activation pattern, ch1 low
  input wire logic [3:0] ext_mode, // External source, ch1 low
  input wire logic [1:0] ext16_valid, // 2-byte threshold strobes
  input wire logic [31:0] ext16, // 2-byte thresholds, ch1 low
  input wire logic [1:0] ext8_valid, // 1-byte threshold strobes
  input wire logic [15:0] ext8, // 1-byte thresholds, ch1 low
  input wire logic [1:0] teach_pin, // Teach objects, async
  input wire logic [7:0] on_dly_sel, // Switch-on delay, ch1 low
  input wire logic [7:0] off_dly_sel, // Switch-off delay, ch1 low
  input wire logic [1:0] send_on_change, // Send on change per channel
  input wire logic [13:0] cyclic, // Cyclic settings, ch1 low
  output logic [1:0] limit_value, // Limit objects
  output logic [1:0] send, // Telegram request pulses
  output logic [31:0] threshold_level // Thresholds in use
);

  // ***************************************************************
  // Second prescaler and teach synchroniser
  // ***************************************************************
  logic [23:0] pre_cnt;
  logic [1:0] teach_s1;
  logic [1:0] teach_s2;
  logic [1:0] teach_s3;
  logic [1:0] teach_lvl;
  logic [1:0] teach_prev;

  localparam logic [23:0] PRE_LAST =
    24'(wind_limit_pkg::SECOND_CYCLES - 1);
  wire sec_tick = (pre_cnt == PRE_LAST);
  // Pulse on a rising, agreed teach level
  wire [1:0] teach_pulse = teach_lvl & ~teach_prev;

  // Prescaler free-runs so delays count in whole seconds
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pre_cnt <= 24'h000000;
    else if (ce)
      pre_cnt <= sec_tick ? 24'h000000 : pre_cnt + 24'h000001;
  end

  // Three stages; level changes only when stages two and three agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      teach_s1 <= 2'h0;
      teach_s2 <= 2'h0;
      teach_s3 <= 2'h0;
      teach_lvl <= 2'h0;
      teach_prev <= 2'h0;
    end
    else if (ce)
    begin
      teach_s1 <= teach_pin;
      teach_s2 <= teach_s1;
      teach_s3 <= teach_s2;
      teach_lvl <= (teach_s2 & teach_s3) | (teach_lvl & (teach_s2 | teach_s3));
      teach_prev <= teach_lvl;
    end
  end

  // ***************************************************************
  // Channels
  // ***************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_ch
      limit_channel u_chan
      (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .enable(ch == 0 ? 1'b1 : both_limits),
        .sec_tick(sec_tick),
        .sample_valid(sample_valid),
        .speed(speed),
        .level_sel(level_sel[ch*4 +: 4]),
        .hyst_sel(hyst_sel[ch*3 +: 3]),
        .pattern(pattern[ch*4 +: 4]),
        .ext_mode(ext_mode[ch*2 +: 2]),
        .ext16_valid(ext16_valid[ch]),
        .ext16(ext16[ch*16 +: 16]),
        .ext8_valid(ext8_valid[ch]),
        .ext8(ext8[ch*8 +: 8]),
        .teach(teach_pulse[ch]),
        .download(download),
        .on_dly_sel(on_dly_sel[ch*4 +: 4]),
        .off_dly_sel(off_dly_sel[ch*4 +: 4]),
        .send_on_change(send_on_change[ch]),
        .cyclic(cyclic[ch*7 +: 7]),
        .limit_value(limit_value[ch]),
        .send(send[ch]),
        .threshold_level(threshold_level[ch*16 +: 16])
      );
    end
  endgenerate

endmodule

// ===== verif/limit_monitor_chk_monitor.sv
/*
  Port checker for the wind limit monitor.
  Assumes it is bound to the top module.
*/
`timescale 1ns/1ps
module limit_monitor_chk
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic both_limits, // Channel 2 on
  input wire logic sample_valid, // Sample strobe
  input wire logic [15:0] speed, // Sample
  input wire logic [7:0] pattern, // Patterns
  input wire logic [3:0] ext_mode, // Sources
  input wire logic [1:0] ext16_valid, // 2-byte strobes
  input wire logic [31:0] ext16, // 2-byte data
  input wire logic [1:0] ext8_valid, // 1-byte strobes
  input wire logic [15:0] ext8, // 1-byte data
  input wire logic [7:0] on_dly_sel, // On delays
  input wire logic [1:0] send_on_change, // Change sends
  input wire logic [13:0] cyclic, // Cyclic settings
  input wire logic [1:0] limit_value, // Objects
  input wire logic [1:0] send, // Telegrams
  input wire logic [31:0] threshold_level // Thresholds
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Channel 1 carries the checks; channel 2 only its idle rule
  a_send_one_pulse: assert property (send[0] |=> !send[0])
    else $error("send held past one cycle");
  a_quiet_never: assert property
    ((!send_on_change[0] && cyclic[6:0] == 7'h00)[*3] |-> !send[0])
    else $error("send with both sends off");
  a_change_sends: assert property
    ($changed(limit_value[0]) && send_on_change[0] && pattern[1:0] == 2'h0
     |-> send[0]) else $error("change not sent");
  a_send_has_cause: assert property
    (send[0] && cyclic[6:0] == 7'h00
     |-> $past(limit_value[0]) != limit_value[0])
    else $error("send without a change");
  a_ch2_idle: assert property ((!both_limits)[*2] |-> !send[1])
    else $error("idle channel sent");
  a_ext16_used: assert property
    (ext_mode[1:0] == 2'h1 && ext16_valid[0]
     |=> threshold_level[15:0] == $past(ext16[15:0]))
    else $error("2-byte threshold not used");
  a_ext8_used: assert property
    (ext_mode[1:0] == 2'h2 && ext8_valid[0]
     |=> threshold_level[15:0] == {8'h00, $past(ext8[7:0])})
    else $error("1-byte threshold not used");
  a_rise_sets: assert property
    (sample_valid && pattern[3:0] == 4'h0 && on_dly_sel[3:0] == 4'h0
     && !limit_value[0] && speed > threshold_level[15:0] ##1 !sample_valid
     |-> ##[1:2] limit_value[0]) else $error("exceed not set");
  c_send: cover property (send[0]);
  c_ch2_set: cover property (limit_value[1]);
  c_ext16: cover property (ext16_valid[0]);
endmodule

bind wind_speed_limit_monitor limit_monitor_chk chk (.clock(clock),
  .rst(rst), .both_limits(both_limits), .sample_valid(sample_valid),
  .speed(speed), .pattern(pattern), .ext_mode(ext_mode),
  .ext16_valid(ext16_valid), .ext16(ext16), .ext8_valid(ext8_valid),
  .ext8(ext8), .on_dly_sel(on_dly_sel), .send_on_change(send_on_change),
  .cyclic(cyclic), .limit_value(limit_value), .send(send),
  .threshold_level(threshold_level));

// ===== verif/setpoint_bus_model.sv
/*
  Bus side model: external threshold senders and teach buttons.
  Assumes the bench calls its tasks; data is scrambled when idle.
*/
`timescale 1ns/1ps
module setpoint_bus_model
(
  input wire logic clock, // System clock
  output logic [1:0] ext16_valid, // 2-byte strobes
  output logic [31:0] ext16, // 2-byte values
  output logic [1:0] ext8_valid, // 1-byte strobes
  output logic [15:0] ext8, // 1-byte values
  output logic [1:0] teach_pin // Teach buttons
);
  // Idle bus, no strobes
  initial
  begin
    ext16_valid = 2'h0;
    ext16 = 32'hA5A5A5A5;
    ext8_valid = 2'h0;
    ext8 = 16'h5A5A;
    teach_pin = 2'h0;
  end

  // Data inverted after the strobe so a stale value cannot pass
  task automatic put16(input logic [15:0] v, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    ext16[15:0] <= v;
    ext16_valid <= 2'h1;
    @(posedge clock);
    ext16_valid <= 2'h0;
    ext16 <= ~ext16;
  endtask

  task automatic put8(input logic [7:0] v, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    ext8[7:0] <= v;
    ext8_valid <= 2'h1;
    @(posedge clock);
    ext8_valid <= 2'h0;
    ext8 <= ~ext8;
  endtask

  // Button held long enough for the synchroniser
  task automatic press;
    @(posedge clock);
    teach_pin <= 2'h1;
    repeat (4) @(posedge clock);
    teach_pin <= 2'h0;
  endtask
endmodule

// ===== verif/testbench.sv
/*
  Bench for the wind limit monitor, delays zero or never expiring, no cyclic sends.
  Assumes a 10 MHz clock; second-based timers are too long to run.
*/
`timescale 1ns/1ps
module testbench;
  logic clock, rst, both_limits, sample_valid, download;
  logic [15:0] speed, ext8;
  logic [7:0] level_sel, pattern, on_dly_sel, off_dly_sel;
  logic [5:0] hyst_sel;
  logic [3:0] ext_mode;
  logic [1:0] ext16_valid, ext8_valid, teach_pin, send_on_change;
  logic [1:0] limit_value, send;
  logic [31:0] ext16, threshold_level;
  logic [13:0] cyclic;
  int failures, tests_run, cycles, sends;
  logic [7:0] tbl [12] = '{8'h01, 8'h03, 8'h05, 8'h08, 8'h0A, 8'h0C,
    8'h0F, 8'h14, 8'h16, 8'h19, 8'h1E, 8'h23};

  wind_speed_limit_monitor dut (.clock(clock), .rst(rst), .ce(1'b1),
    .both_limits(both_limits), .sample_valid(sample_valid), .speed(speed),
    .download(download), .level_sel(level_sel), .hyst_sel(hyst_sel),
    .pattern(pattern), .ext_mode(ext_mode), .ext16_valid(ext16_valid),
    .ext16(ext16), .ext8_valid(ext8_valid), .ext8(ext8),
    .teach_pin(teach_pin), .on_dly_sel(on_dly_sel),
    .off_dly_sel(off_dly_sel), .send_on_change(send_on_change),
    .cyclic(cyclic), .limit_value(limit_value), .send(send),
    .threshold_level(threshold_level));

  setpoint_bus_model model (.clock(clock), .ext16_valid(ext16_valid),
    .ext16(ext16), .ext8_valid(ext8_valid), .ext8(ext8),
    .teach_pin(teach_pin));

  // Free running clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One sample, then count channel 1 telegrams
  task automatic sample(input logic [15:0] v);
    @(posedge clock);
    speed <= v;
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    sends = 0;
    repeat (6)
    begin
      @(negedge clock);
      if (send[0] === 1'b1)
        sends++;
    end
  endtask

  task automatic step(input logic [15:0] v, input logic lim, input int n);
    sample(v);
    check({15'h0000, limit_value[0]}, {15'h0000, lim});
    check(16'(sends), 16'(n));
  endtask

  // Hang guard, far above the expected run
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst = 1'b1;
    both_limits = 1'b0;
    sample_valid = 1'b0;
    download = 1'b0;
    speed = 16'h0000;
    level_sel = 8'h22;
    hyst_sel = 6'h12;
    pattern = 8'h00;
    ext_mode = 4'h0;
    on_dly_sel = 8'h00;
    off_dly_sel = 8'h00;
    send_on_change = 2'h3;
    cyclic = 14'h0000;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check({14'h0000, limit_value}, 16'h0000);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clock);
      level_sel <= {4'h2, 4'(i)};
      @(negedge clock);
      check(threshold_level[15:0], {8'h00, tbl[i]});
    end
    check(threshold_level[31:16], 16'h0005);
    level_sel <= 8'h22;
    step(16'h0006, 1'b1, 1);
    step(16'h0003, 1'b1, 0);
    step(16'h0001, 1'b0, 1);
    check({15'h0000, limit_value[1]}, 16'h0000);
    send_on_change <= 2'h2;
    step(16'h0006, 1'b1, 0);
    step(16'h0001, 1'b0, 0);
    send_on_change <= 2'h3;
    pattern <= 8'h04;
    step(16'h0001, 1'b1, 1);
    step(16'h0006, 1'b0, 1);
    pattern <= 8'h08;
    step(16'h0004, 1'b1, 1);
    step(16'h0008, 1'b1, 0);
    step(16'h0009, 1'b0, 1);
    pattern <= 8'h01;
    step(16'h0006, 1'b1, 1);
    sample(16'h0001);
    check(16'(sends), 16'h0000);
    pattern <= 8'h02;
    step(16'h0006, 1'b1, 0);
    step(16'h0001, 1'b0, 1);
    pattern <= 8'h00;
    both_limits <= 1'b1;
    sample(16'h0006);
    check({15'h0000, limit_value[1]}, 16'h0001);
    ext_mode <= 4'h1;
    model.put16(16'h0030, 0);
    @(negedge clock);
    check(threshold_level[15:0], 16'h0030);
    ext_mode <= 4'h2;
    model.put8(8'h21, 3);
    @(negedge clock);
    check(threshold_level[15:0], 16'h0021);
    @(posedge clock);
    download <= 1'b1;
    @(posedge clock);
    download <= 1'b0;
    @(negedge clock);
    check(threshold_level[15:0], 16'h0005);
    sample(16'h0012);
    model.press();
    repeat (6) @(negedge clock);
    check(threshold_level[15:0], 16'h0012);
    // Delays of a second never expire here, so the old value must stand
    off_dly_sel <= 8'h01;
    step(16'h0001, 1'b1, 0);
    step(16'h0014, 1'b1, 0);
    off_dly_sel <= 8'h00;
    step(16'h0001, 1'b0, 1);
    on_dly_sel <= 8'h01;
    step(16'h0014, 1'b0, 0);
    tally_and_finish();
  end
endmodule
